// ### rtl/kwi_pkg.sv
// kwi_pkg: constants, register map and carrier types for the keypad wakeup interrupt unit
// assumes a single 200 MHz clock domain and an apb register bus
package kwi_pkg;
  localparam int unsigned KWI_PINS = 5;
  localparam logic [11:0] KWI_OFF_STATUS_CONTROL = 12'h000;
  localparam logic [11:0] KWI_OFF_PIN_ENABLE = 12'h004;
  localparam logic [11:0] KWI_OFF_IRQ_STATUS = 12'h008;
  localparam logic [11:0] KWI_OFF_IRQ_CLEAR = 12'h00c;
  localparam logic [11:0] KWI_OFF_IRQ_ENABLE = 12'h010;
  localparam int unsigned KWI_BIT_MODE = 0;
  localparam int unsigned KWI_BIT_MASK = 1;
  localparam int unsigned KWI_BIT_ACK = 2;
  localparam int unsigned KWI_BIT_FLAG = 3;
  localparam int unsigned KWI_EVT_LATCH = 0;
  localparam int unsigned KWI_EVT_CLEAR = 1;
  localparam logic [4:0] KWI_PIN_ENABLE_RESET = 5'h00;
  localparam logic [1:0] KWI_EVT_RESET = 2'h0;
  localparam logic [4:0] KWI_SYNC_RESET = 5'h1f;

  typedef struct packed {
    logic [11:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } kwi_apb_req_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } kwi_apb_rsp_type;
endpackage : kwi_pkg

// ### rtl/kwi_sync.sv
// kwi_sync: two-flop synchroniser for the keypad pins
// assumes pins idle high, so flops reset to one
`timescale 1ns/1ps
`default_nettype none
module kwi_sync
  import kwi_pkg::*;
#(
  parameter int unsigned WIDTH = 5
)
(
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } kwi_sync_state_type;

  kwi_sync_state_type s_q;
  kwi_sync_state_type s_d;

  always_comb
  begin
    s_d.meta = async_in;
    s_d.stable = s_q.meta;
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      s_q <= '{meta: {WIDTH{1'b1}}, stable: {WIDTH{1'b1}}};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign sync_out = s_q.stable;
endmodule : kwi_sync
`default_nettype wire

// ### rtl/kwi_unit.sv
// kwi_unit: keypad wakeup interrupt unit with apb registers
// assumes synchronous apb master on ref_clk_in; pins asynchronous, idle high
// Contract
// - writing one to acknowledge clears request
// - acknowledge bit always reads zero
// - mask bit set blocks processor interrupt
// - reset clears mask, acknowledge, sensitivity bits
// - sensitivity selects edge-only or edge-plus-level
// - enabled pins latch requests, others ignored
// - reset clears all pin enable bits
// - latch when enabled pin falls, all high before
// - level mode clears after ack and pins high
// - edge mode ack clears request at once
// - vector fetch acts as an acknowledge
//
// Added by the designer: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module kwi_unit
  import kwi_pkg::*;
#(
  parameter int unsigned PINS = KWI_PINS
)
(
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  input wire kwi_pkg::kwi_apb_req_type apb_req_in,
  output kwi_pkg::kwi_apb_rsp_type apb_rsp_out,
  input wire logic [PINS-1:0] keypad_pins_in,
  input wire logic vector_fetch_in,
  output logic keypad_irq_out,
  output logic event_irq_out
);
  import kwi_pkg::*;

  typedef struct packed {
    logic mode;
    logic mask;
    logic [PINS-1:0] pin_en;
    logic request;
    logic ack_seen;
    logic all_high;
    logic [1:0] evt_status;
    logic [1:0] evt_enable;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic keypad_irq;
    logic event_irq;
  } kwi_state_type;

  kwi_state_type s_q;
  kwi_state_type s_d;
  logic [PINS-1:0] pins_sync;
  logic access;
  logic wr;
  logic ack_wr;
  logic ack;
  logic any_low;
  logic latch_evt;
  logic clear_evt;
  logic next_req;

  kwi_sync #(
    .WIDTH(PINS)
  ) u_sync (
    .ref_clk_in(ref_clk_in),
    .resetn_in(resetn_in),
    .async_in(keypad_pins_in),
    .sync_out(pins_sync)
  );

  always_comb
  begin
    s_d = s_q;
    access = apb_req_in.psel && apb_req_in.penable && !s_q.pready;
    wr = access && apb_req_in.pwrite;
    ack_wr = wr && (apb_req_in.paddr == KWI_OFF_STATUS_CONTROL) &&
             apb_req_in.pwdata[KWI_BIT_ACK];
    ack = ack_wr || vector_fetch_in;
    any_low = |(~pins_sync & s_q.pin_en);
    // falling edge of the combined line, only after all enabled pins were high
    latch_evt = any_low && s_q.all_high;
    next_req = s_q.request;
    if (s_q.request)
    begin
      if (!s_q.mode)
      begin
        if (ack)
        begin
          next_req = 1'b0;
        end
      end
      else if ((ack || s_q.ack_seen) && !any_low)
      begin
        next_req = 1'b0;
      end
    end
    if (latch_evt)
    begin
      next_req = 1'b1;
    end
    clear_evt = s_q.request && !next_req;
    s_d.request = next_req;
    s_d.ack_seen = next_req && s_q.mode && (s_q.ack_seen || ack) && !latch_evt;
    s_d.all_high = !any_low;
    s_d.pready = access;
    s_d.pslverr = 1'b0;
    s_d.prdata = 32'h0000_0000;
    if (wr)
    begin
      case (apb_req_in.paddr)
        KWI_OFF_STATUS_CONTROL:
        begin
          s_d.mode = apb_req_in.pwdata[KWI_BIT_MODE];
          s_d.mask = apb_req_in.pwdata[KWI_BIT_MASK];
        end
        KWI_OFF_PIN_ENABLE: s_d.pin_en = apb_req_in.pwdata[PINS-1:0];
        KWI_OFF_IRQ_ENABLE: s_d.evt_enable = apb_req_in.pwdata[1:0];
        KWI_OFF_IRQ_STATUS: s_d.pslverr = 1'b0;
        KWI_OFF_IRQ_CLEAR: s_d.pslverr = 1'b0;
        default: s_d.pslverr = 1'b1;
      endcase
    end
    else if (access)
    begin
      case (apb_req_in.paddr)
        KWI_OFF_STATUS_CONTROL:
        begin
          s_d.prdata[KWI_BIT_MODE] = s_q.mode;
          s_d.prdata[KWI_BIT_MASK] = s_q.mask;
          s_d.prdata[KWI_BIT_ACK] = 1'b0;
          s_d.prdata[KWI_BIT_FLAG] = s_q.request;
        end
        KWI_OFF_PIN_ENABLE: s_d.prdata[PINS-1:0] = s_q.pin_en;
        KWI_OFF_IRQ_STATUS: s_d.prdata[1:0] = s_q.evt_status;
        KWI_OFF_IRQ_ENABLE: s_d.prdata[1:0] = s_q.evt_enable;
        KWI_OFF_IRQ_CLEAR: s_d.prdata = 32'h0000_0000;
        default: s_d.pslverr = 1'b1;
      endcase
    end
    // write-one clears, then new events set; set wins
    if (wr && (apb_req_in.paddr == KWI_OFF_IRQ_CLEAR))
    begin
      s_d.evt_status = s_q.evt_status & ~apb_req_in.pwdata[1:0];
    end
    if (latch_evt)
    begin
      s_d.evt_status[KWI_EVT_LATCH] = 1'b1;
    end
    if (clear_evt)
    begin
      s_d.evt_status[KWI_EVT_CLEAR] = 1'b1;
    end
    s_d.keypad_irq = next_req && !s_d.mask;
    s_d.event_irq = |(s_d.evt_status & s_d.evt_enable);
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      s_q.mode <= 1'b0;
      s_q.mask <= 1'b0;
      s_q.pin_en <= KWI_PIN_ENABLE_RESET;
      s_q.request <= 1'b0;
      s_q.ack_seen <= 1'b0;
      s_q.all_high <= 1'b1;
      s_q.evt_status <= KWI_EVT_RESET;
      s_q.evt_enable <= KWI_EVT_RESET;
      s_q.prdata <= 32'h0000_0000;
      s_q.pready <= 1'b0;
      s_q.pslverr <= 1'b0;
      s_q.keypad_irq <= 1'b0;
      s_q.event_irq <= 1'b0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign apb_rsp_out.prdata = s_q.prdata;
  assign apb_rsp_out.pready = s_q.pready;
  assign apb_rsp_out.pslverr = s_q.pslverr;
  assign keypad_irq_out = s_q.keypad_irq;
  assign event_irq_out = s_q.event_irq;

  a_mask_gates_irq: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    keypad_irq_out |-> (s_q.request && !s_q.mask))
    else $error("irq high while masked or idle");

  a_ack_reads_zero: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    apb_rsp_out.pready |-> !apb_rsp_out.prdata[KWI_BIT_ACK])
    else $error("acknowledge bit read as one");

  a_edge_ack_clears: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    (s_q.request && !s_q.mode && vector_fetch_in && !latch_evt) |=> !s_q.request)
    else $error("edge mode acknowledge did not clear");

  a_write_ack_clears: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    (s_q.request && !s_q.mode && ack_wr && !latch_evt) |=> !s_q.request)
    else $error("software acknowledge did not clear");

  a_latch_on_fall: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    (s_q.all_high && any_low) |=> s_q.request)
    else $error("enabled fall not latched");

  a_no_latch_low: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    (!s_q.request && !s_q.all_high) |=> !s_q.request)
    else $error("latched while a pin already low");

  a_level_holds: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    (s_q.request && s_q.mode && any_low) |=> s_q.request)
    else $error("level request cleared while pin low");

  a_disabled_ignored: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    (s_q.pin_en == '0) |-> !any_low)
    else $error("disabled pin seen low");

  a_apb_one_wait: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    (apb_req_in.psel && apb_req_in.penable && !s_q.pready) |=> apb_rsp_out.pready)
    else $error("apb answer late");

  // level mode clear steps: acknowledge kept while low, then pins back high
  sequence s_level_ack_low;
    s_q.request && s_q.mode && ack && any_low && !latch_evt;
  endsequence

  sequence s_ack_held_low;
    s_q.request && s_q.mode && s_q.ack_seen && any_low && !latch_evt;
  endsequence

  sequence s_pins_back;
    s_q.mode && !any_low;
  endsequence

  a_level_ack_kept: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    s_level_ack_low |=> (s_q.request && s_q.ack_seen))
    else $error("level acknowledge not remembered");

  a_level_release: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    s_ack_held_low ##1 s_pins_back |=> !s_q.request)
    else $error("level request kept after ack and release");

  a_level_needs_ack: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    (s_q.request && s_q.mode && !s_q.ack_seen && !ack) |=> s_q.request)
    else $error("level request cleared without ack");

  a_fetch_remembered: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    (s_q.request && s_q.mode && vector_fetch_in && any_low && !latch_evt) |=> s_q.ack_seen)
    else $error("vector fetch not taken as acknowledge");

  a_edge_no_ack_holds: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    (s_q.request && !s_q.mode && !ack) |=> s_q.request)
    else $error("edge request cleared without ack");

  a_reset_ctl_clear: assert property (@(posedge ref_clk_in)
    !resetn_in |=> (!s_q.mode && !s_q.mask && !s_q.ack_seen))
    else $error("control bits not cleared by reset");

  a_reset_pins_clear: assert property (@(posedge ref_clk_in)
    !resetn_in |=> (s_q.pin_en == KWI_PIN_ENABLE_RESET))
    else $error("pin enables not cleared by reset");

  a_mode_write: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    (wr && apb_req_in.paddr == KWI_OFF_STATUS_CONTROL) |=> (s_q.mode == $past(apb_req_in.pwdata[KWI_BIT_MODE])))
    else $error("sensitivity bit not written");

  a_mask_write: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    (wr && apb_req_in.paddr == KWI_OFF_STATUS_CONTROL) |=> (s_q.mask == $past(apb_req_in.pwdata[KWI_BIT_MASK])))
    else $error("mask bit not written");

  a_pin_en_write: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    (wr && apb_req_in.paddr == KWI_OFF_PIN_ENABLE) |=> (s_q.pin_en == $past(apb_req_in.pwdata[PINS-1:0])))
    else $error("pin enables not written");

  a_flag_read: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    (access && !apb_req_in.pwrite && apb_req_in.paddr == KWI_OFF_STATUS_CONTROL)
    |=> (apb_rsp_out.prdata[KWI_BIT_FLAG] == $past(s_q.request)))
    else $error("pending flag read wrong");

  a_mode_read: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    (access && !apb_req_in.pwrite && apb_req_in.paddr == KWI_OFF_STATUS_CONTROL)
    |=> (apb_rsp_out.prdata[KWI_BIT_MODE] == $past(s_q.mode)))
    else $error("sensitivity bit read wrong");

  a_unmasked_irq: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    (s_q.request && !s_q.mask) |-> keypad_irq_out)
    else $error("unmasked request without irq");

  a_no_low_no_latch: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    (!s_q.request && !any_low) |=> !s_q.request)
    else $error("latched with no enabled pin low");

  a_pready_pulse: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    apb_rsp_out.pready |=> !apb_rsp_out.pready)
    else $error("apb ready held too long");

  a_event_set_wins: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    latch_evt |=> s_q.evt_status[KWI_EVT_LATCH])
    else $error("latch event not recorded");

  a_event_clear_mark: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    clear_evt |=> s_q.evt_status[KWI_EVT_CLEAR])
    else $error("clear event not recorded");
endmodule : kwi_unit
`default_nettype wire

// ### sim/kwi_keypad_model.sv
// kwi_keypad_model: five keypad switches on the unit's pins
// assumes pull-ups, so a released line reads high
`timescale 1ns/1ps
`default_nettype none
module kwi_keypad_model
(
  input wire logic ref_clk_in,
  input wire logic [4:0] press_in,
  output logic [4:0] pins_out
);
  // pressed key pulls its line low
  always_ff @(posedge ref_clk_in)
  begin
    pins_out <= ~press_in;
  end
endmodule : kwi_keypad_model
`default_nettype wire

// ### sim/tb_top.sv
// tb_top: self-checking bench for the keypad wakeup interrupt unit
// assumes the unit's apb timing and the keypad model beside it
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import kwi_pkg::*;
  logic ref_clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic vector_fetch_in = 1'b0;
  logic [4:0] press_q = 5'h00;
  logic [4:0] pins;
  logic irq;
  logic evt;
  logic err;
  kwi_apb_req_type req = '0;
  kwi_apb_rsp_type rsp;
  int n_mismatch = 0;
  int tests_run = 0;
  logic [31:0] rd;
  logic [31:0] d;
  logic mode_q = 1'b0;
  logic mask_q = 1'b0;
  logic req_q = 1'b0;
  always #2.5 ref_clk_in = ~ref_clk_in;
  kwi_keypad_model keys (.ref_clk_in(ref_clk_in), .press_in(press_q), .pins_out(pins));
  kwi_unit dut (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .apb_req_in(req), .apb_rsp_out(rsp),
    .keypad_pins_in(pins), .vector_fetch_in(vector_fetch_in), .keypad_irq_out(irq), .event_irq_out(evt));

  task conclude;
    $display("mismatches %0d of %0d checks", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : conclude

  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task apb(input logic [11:0] a, input logic w, input logic [31:0] wd);
    int i;
    req.paddr <= a;
    req.pwrite <= w;
    req.pwdata <= wd;
    req.psel <= 1'b1;
    @(posedge ref_clk_in);
    req.penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge ref_clk_in);
      i++;
    end
    while (rsp.pready !== 1'b1 && i < 20);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    @(posedge ref_clk_in);
    if (i >= 20)
    begin
      n_mismatch++;
      conclude();
    end
  endtask : apb

  // read status and compare it and the irq line with the model
  task status;
    apb(KWI_OFF_STATUS_CONTROL, 1'b0, 32'h0);
    chk("status", rd, {28'h0, req_q, 1'b0, mask_q, mode_q});
    chk("irq", {31'h0, irq}, {31'h0, req_q & ~mask_q});
  endtask : status

  task ctl(input logic mo, input logic ma, input logic ack);
    apb(KWI_OFF_STATUS_CONTROL, 1'b1, {29'h0, ack, ma, mo});
    mode_q = mo;
    mask_q = ma;
  endtask : ctl

  task press(input logic [4:0] p, input logic exp);
    press_q <= p;
    repeat (6) @(posedge ref_clk_in);
    req_q = exp;
    status();
  endtask : press

  initial
  begin
    void'($urandom(32'hcdc4b44c));
    repeat (3) @(posedge ref_clk_in);
    resetn_in <= 1'b1;
    status();
    apb(KWI_OFF_PIN_ENABLE, 1'b0, 32'h0);
    chk("enable reset", rd, 32'h0);
    d = $urandom;
    apb(KWI_OFF_PIN_ENABLE, 1'b1, d);
    apb(KWI_OFF_PIN_ENABLE, 1'b0, 32'h0);
    chk("enable", rd, {27'h0, d[4:0]});
    apb(KWI_OFF_PIN_ENABLE, 1'b1, 32'h3);
    apb(KWI_OFF_IRQ_ENABLE, 1'b1, 32'h1);
    press(5'h01, 1'b1);
    chk("event irq", {31'h0, evt}, 32'h1);
    apb(KWI_OFF_IRQ_STATUS, 1'b0, 32'h0);
    chk("event status", rd, 32'h1);
    apb(KWI_OFF_IRQ_CLEAR, 1'b1, 32'h3);
    chk("event clear", {31'h0, evt}, 32'h0);
    ctl(1'b0, 1'b1, 1'b0);
    status();
    ctl(1'b0, 1'b0, 1'b1);
    req_q = 1'b0;
    status();
    apb(KWI_OFF_IRQ_STATUS, 1'b0, 32'h0);
    chk("clear event", rd, 32'h2);
    press(5'h03, 1'b0);
    press(5'h00, 1'b0);
    press(5'h10, 1'b0);
    press(5'h00, 1'b0);
    ctl(1'b1, 1'b0, 1'b0);
    press(5'h02, 1'b1);
    ctl(1'b1, 1'b0, 1'b1);
    status();
    press(5'h00, 1'b0);
    press(5'h01, 1'b1);
    vector_fetch_in <= 1'b1;
    @(posedge ref_clk_in);
    vector_fetch_in <= 1'b0;
    status();
    press(5'h00, 1'b0);
    ctl(1'b0, 1'b0, 1'b0);
    press(5'h01, 1'b1);
    vector_fetch_in <= 1'b1;
    @(posedge ref_clk_in);
    vector_fetch_in <= 1'b0;
    req_q = 1'b0;
    status();
    press(5'h00, 1'b0);
    ctl(1'b1, 1'b1, 1'b0);
    press(5'h01, 1'b1);
    resetn_in <= 1'b0;
    repeat (3) @(posedge ref_clk_in);
    resetn_in <= 1'b1;
    mode_q = 1'b0;
    mask_q = 1'b0;
    req_q = 1'b0;
    status();
    apb(KWI_OFF_PIN_ENABLE, 1'b0, 32'h0);
    chk("enable after reset", rd, 32'h0);
    press(5'h00, 1'b0);
    apb(12'h0ff, 1'b0, 32'h0);
    chk("unmapped", {31'h0, err}, 32'h1);
    conclude();
  end
endmodule : tb_top
`default_nettype wire
